// file: logic/aogc_pkg.sv
`default_nettype none

package aogc_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int RAW_W = 24;
    localparam int OUT_W = 16;
    localparam int GAIN_FRAC = 23;
    localparam int DIV_STEPS = 47;

    // ----------------------------------------
    // reset values of the correction registers and the largest gain correction
    // ----------------------------------------
    localparam logic [23:0] OFFSET_RESET = 24'h00_0000;
    localparam logic [23:0] GAIN_RESET = 24'h80_0000;
    localparam logic [23:0] GAIN_MAX = 24'hFF_FFFF;

    // ----------------------------------------
    // output limits
    // ----------------------------------------
    localparam logic [15:0] BIP_MAX = 16'h7FFF;
    localparam logic [15:0] BIP_MIN = 16'h8000;
    localparam logic [15:0] UNI_MAX = 16'hFFFF;
    localparam logic [15:0] UNI_MIN = 16'h0000;
    localparam logic signed [31:0] SCALED_POS_LIMIT = 32'sh007F_FFFF;
    localparam logic signed [31:0] SCALED_NEG_LIMIT = -32'sh0080_0000;
    localparam logic signed [31:0] SCALED_UNI_LIMIT = 32'sh00FF_FFFF;

    // ----------------------------------------
    // input selection codes for the internal temperature sensor
    // ----------------------------------------
    localparam logic [3:0] TEMP_POS_CODE = 4'h7;
    localparam logic [3:0] TEMP_NEG_CODE = 4'h0;

    typedef enum logic [2:0] {
        CAL_NONE,
        CAL_SELF_OFS,
        CAL_SELF_GAIN,
        CAL_SYS_OFS,
        CAL_SYS_GAIN
    } aogc_cal_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DIV
    } aogc_state_t;

endpackage : aogc_pkg

`default_nettype wire

// file: logic/aogc_calibration.sv
`default_nettype none

// Operation
// [R1] the correction path carries 24-bit raw results, always bipolar internally
// [R2] reset leaves offset correction zero and gain correction at unity
// [R3] result is raw minus offset, times gain correction, times selected gain
// [R4] unipolar mode clamps negatives to zero and doubles the value
// [R5] self offset calibration shorts inputs and captures the raw result as offset
// [R6] self gain calibration connects reference and sets gain to 1/(raw-offset)
// [R7] self calibration results land in the registers without host action
// [R8] host applies zero input for offset step, full scale for gain step
// [R9] system calibration stores its offset and gain results automatically
// [R10] host should calibrate offset first and gain afterwards
// [R11] offset correction is read as signed two's complement
// [R12] gain correction is unsigned, one integer bit and 23 fraction bits
// [R13] host should not load a gain correction below one half
// [R14] setting changes leave the held result alone until next conversion
// [R15] host selects positive code 0111 and negative code 0000 for temp sensor
// [R16] applied gain comes from the two-bit gain field
// [R17] host should convert at the calibration conversion rate
// [R18] unipolar results are plain binary, bipolar ones two's complement
// [R19] unipolar spans 0..65535, bipolar -32768..32767
// [R20] scaled values beyond full scale saturate instead of wrapping
module aogc_calibration (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RAW_VALID,
    input wire logic [23:0] RAW_DATA,
    input wire logic [1:0] GAIN_SEL,
    input wire logic UNIPOLAR,
    input wire logic CAL_START,
    input wire aogc_pkg::aogc_cal_t CAL_SEL,
    input wire logic OFFSET_WR,
    input wire logic [23:0] OFFSET_WDATA,
    input wire logic GAIN_WR,
    input wire logic [23:0] GAIN_WDATA,
    input wire logic [3:0] POSITIVE_INPUT_SELECT,
    input wire logic [3:0] NEGATIVE_INPUT_SELECT,
    output logic [15:0] RESULT,
    output logic RESULT_VALID,
    output logic [23:0] OFFSET_CORRECTION_VALUE,
    output logic [23:0] GAIN_CORRECTION_VALUE,
    output logic CAL_BUSY,
    output logic SHORT_INPUTS,
    output logic REF_TO_INPUT,
    output logic TEMP_SENSOR_ON
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    aogc_pkg::aogc_state_t state;
    aogc_pkg::aogc_cal_t cal_op;
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [26:0] corr;
    logic [2:0] shift;
    logic signed [31:0] scaled;
    logic [15:0] next_result;
    logic conv_done;
    logic ofs_capture;
    logic gain_capture;
    logic [24:0] divisor;
    logic [25:0] div_rem;
    logic [46:0] div_q;
    logic [5:0] div_cnt;
    logic [25:0] rem_sh;
    logic gain_load;
    logic [23:0] gain_new;

    // ----------------------------------------
    // correction datapath
    // ----------------------------------------
    // offset is signed, gain is unsigned 1.23 fixed point
    assign diff = $signed({RAW_DATA[23], RAW_DATA})
        - $signed({OFFSET_CORRECTION_VALUE[23], OFFSET_CORRECTION_VALUE}); // [R1] [R11]
    assign prod = 50'(diff) * $signed({26'h000_0000, GAIN_CORRECTION_VALUE}); // [R3] [R12]
    assign corr = prod[49:23];
    // unipolar adds one more doubling on top of the selected gain
    assign shift = {1'b0, GAIN_SEL} + {2'b00, UNIPOLAR}; // [R4] [R16]
    assign scaled = 32'(corr) <<< shift; // [R3]

    always_comb
    begin
        if (UNIPOLAR)
        begin
            if (corr < 0)
                next_result = aogc_pkg::UNI_MIN; // [R4]
            else if (scaled > aogc_pkg::SCALED_UNI_LIMIT)
                next_result = aogc_pkg::UNI_MAX; // [R20]
            else
                next_result = scaled[23:8]; // [R18] [R19]
        end
        else
        begin
            if (scaled > aogc_pkg::SCALED_POS_LIMIT)
                next_result = aogc_pkg::BIP_MAX; // [R20]
            else if (scaled < aogc_pkg::SCALED_NEG_LIMIT)
                next_result = aogc_pkg::BIP_MIN; // [R20]
            else
                next_result = scaled[23:8]; // [R18] [R19]
        end
    end

    // calibration conversions never reach the result register
    assign conv_done = RAW_VALID && (state == aogc_pkg::ST_IDLE);

    // ----------------------------------------
    // result register
    // ----------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            RESULT <= 16'h0000;
        else if (conv_done)
            RESULT <= next_result; // [R14]
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            RESULT_VALID <= 1'b0;
        else
            RESULT_VALID <= conv_done;
    end

    // ----------------------------------------
    // calibration sequencer
    // ----------------------------------------
    assign ofs_capture = (state == aogc_pkg::ST_WAIT) && RAW_VALID
        && (cal_op == aogc_pkg::CAL_SELF_OFS || cal_op == aogc_pkg::CAL_SYS_OFS);
    assign gain_capture = (state == aogc_pkg::ST_WAIT) && RAW_VALID
        && (cal_op == aogc_pkg::CAL_SELF_GAIN || cal_op == aogc_pkg::CAL_SYS_GAIN);

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state <= aogc_pkg::ST_IDLE;
            cal_op <= aogc_pkg::CAL_NONE;
        end
        else
        begin
            case (state)
                aogc_pkg::ST_IDLE:
                begin
                    // a start while busy is ignored, so is CAL_NONE
                    if (CAL_START && CAL_SEL != aogc_pkg::CAL_NONE)
                    begin
                        state <= aogc_pkg::ST_WAIT;
                        cal_op <= CAL_SEL;
                    end
                end
                aogc_pkg::ST_WAIT:
                begin
                    if (ofs_capture)
                        state <= aogc_pkg::ST_IDLE; // [R7] [R9]
                    else if (gain_capture && diff > 0)
                        state <= aogc_pkg::ST_DIV;
                    else if (gain_capture)
                        state <= aogc_pkg::ST_IDLE;
                end
                aogc_pkg::ST_DIV:
                begin
                    if (div_cnt == 6'(aogc_pkg::DIV_STEPS - 1))
                        state <= aogc_pkg::ST_IDLE;
                end
                default:
                    state <= aogc_pkg::ST_IDLE;
            endcase
        end
    end

    always_comb
    begin
        CAL_BUSY = (state != aogc_pkg::ST_IDLE);
        SHORT_INPUTS = (state == aogc_pkg::ST_WAIT) && (cal_op == aogc_pkg::CAL_SELF_OFS); // [R5]
        REF_TO_INPUT = (state == aogc_pkg::ST_WAIT) && (cal_op == aogc_pkg::CAL_SELF_GAIN); // [R6]
        TEMP_SENSOR_ON = (POSITIVE_INPUT_SELECT == aogc_pkg::TEMP_POS_CODE)
            && (NEGATIVE_INPUT_SELECT == aogc_pkg::TEMP_NEG_CODE);
    end

    // ----------------------------------------
    // reciprocal divider: 2^46 / (raw - offset)
    // ----------------------------------------
    // one quotient bit per clock; full scale 2^23 gives exactly unity
    assign rem_sh = {div_rem[24:0], div_cnt == 6'd0};

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            divisor <= 25'h000_0000;
            div_rem <= 26'h000_0000;
            div_q <= 47'h0000_0000_0000;
            div_cnt <= 6'd0;
        end
        else if (gain_capture)
        begin
            divisor <= diff[24:0]; // [R6]
            div_rem <= 26'h000_0000;
            div_q <= 47'h0000_0000_0000;
            div_cnt <= 6'd0;
        end
        else if (state == aogc_pkg::ST_DIV)
        begin
            div_cnt <= div_cnt + 6'd1;
            if (rem_sh >= {1'b0, divisor})
            begin
                div_rem <= rem_sh - {1'b0, divisor};
                div_q <= {div_q[45:0], 1'b1};
            end
            else
            begin
                div_rem <= rem_sh;
                div_q <= {div_q[45:0], 1'b0};
            end
        end
    end

    always_comb
    begin
        gain_load = 1'b0;
        gain_new = aogc_pkg::GAIN_MAX;
        if (gain_capture && !(diff > 0))
            gain_load = 1'b1; // non-positive span: largest gain
        else if (state == aogc_pkg::ST_DIV && div_cnt == 6'(aogc_pkg::DIV_STEPS - 1))
        begin
            gain_load = 1'b1;
            // the final quotient bit is not yet in div_q
            if (div_q[45:23] != 23'h00_0000)
                gain_new = aogc_pkg::GAIN_MAX; // [R12]
            else
                gain_new = {div_q[22:0], rem_sh >= {1'b0, divisor}}; // [R6]
        end
    end

    // ----------------------------------------
    // correction registers
    // ----------------------------------------
    // calibration updates win over a host write in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            OFFSET_CORRECTION_VALUE <= aogc_pkg::OFFSET_RESET; // [R2]
        else if (ofs_capture)
            OFFSET_CORRECTION_VALUE <= RAW_DATA; // [R5] [R7] [R9]
        else if (OFFSET_WR)
            OFFSET_CORRECTION_VALUE <= OFFSET_WDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            GAIN_CORRECTION_VALUE <= aogc_pkg::GAIN_RESET; // [R2]
        else if (gain_load)
            GAIN_CORRECTION_VALUE <= gain_new; // [R7] [R9]
        else if (GAIN_WR && state != aogc_pkg::ST_DIV)
            GAIN_CORRECTION_VALUE <= GAIN_WDATA;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_reset_values;
        @(posedge CLK) !RST_N |=> OFFSET_CORRECTION_VALUE == aogc_pkg::OFFSET_RESET
            && GAIN_CORRECTION_VALUE == aogc_pkg::GAIN_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) // [R2]
        else $error("correction registers not at reset values");

    property p_unity_path;
        @(posedge CLK) disable iff (!RST_N)
        (conv_done && !UNIPOLAR && GAIN_SEL == 2'b00
            && GAIN_CORRECTION_VALUE == aogc_pkg::GAIN_RESET
            && OFFSET_CORRECTION_VALUE == aogc_pkg::OFFSET_RESET)
        |=> RESULT == $past(RAW_DATA[23:8]) && RESULT_VALID;
    endproperty
    a_unity_path: assert property (p_unity_path) // [R3]
        else $error("unity corrections did not pass raw data through");

    property p_gain_field;
        @(posedge CLK) disable iff (!RST_N)
        (conv_done && !UNIPOLAR && GAIN_SEL == 2'b01 && OFFSET_CORRECTION_VALUE == 24'h00_0000
            && GAIN_CORRECTION_VALUE == 24'h80_0000 && RAW_DATA == 24'h00_4000)
        |=> RESULT == 16'h0080;
    endproperty
    a_gain_field: assert property (p_gain_field) // [R16]
        else $error("gain field of two not applied");

    property p_uni_clamp;
        @(posedge CLK) disable iff (!RST_N)
        (conv_done && UNIPOLAR && corr < 0) |=> RESULT == aogc_pkg::UNI_MIN;
    endproperty
    a_uni_clamp: assert property (p_uni_clamp) // [R4]
        else $error("negative unipolar value not clamped to zero");

    property p_bip_sat;
        @(posedge CLK) disable iff (!RST_N)
        (conv_done && !UNIPOLAR && scaled > aogc_pkg::SCALED_POS_LIMIT)
        |=> RESULT == aogc_pkg::BIP_MAX;
    endproperty
    a_bip_sat: assert property (p_bip_sat) // [R20]
        else $error("bipolar overrange did not saturate");

    property p_hold;
        @(posedge CLK) disable iff (!RST_N)
        !conv_done |=> $stable(RESULT) && !RESULT_VALID;
    endproperty
    a_hold: assert property (p_hold) // [R14]
        else $error("result changed without a conversion");

    property p_self_offset;
        @(posedge CLK) disable iff (!RST_N)
        (ofs_capture && cal_op == aogc_pkg::CAL_SELF_OFS && SHORT_INPUTS)
        |=> OFFSET_CORRECTION_VALUE == $past(RAW_DATA) && !CAL_BUSY;
    endproperty
    a_self_offset: assert property (p_self_offset) // [R5]
        else $error("self offset result not stored");

    property p_ref_connect;
        @(posedge CLK) disable iff (!RST_N)
        (REF_TO_INPUT && RAW_VALID && diff > 0) |=> !REF_TO_INPUT && !SHORT_INPUTS
            && CAL_BUSY;
    endproperty
    a_ref_connect: assert property (p_ref_connect) // [R6]
        else $error("reference not released after self gain capture");

    property p_gain_done;
        @(posedge CLK) disable iff (!RST_N)
        (gain_capture && diff == 25'sh080_0000)
        |-> ##48 (GAIN_CORRECTION_VALUE == aogc_pkg::GAIN_RESET && !CAL_BUSY);
    endproperty
    a_gain_done: assert property (p_gain_done) // [R9]
        else $error("full scale span did not yield unity gain in time");

endmodule : aogc_calibration

`default_nettype wire

// file: test/aogc_filter_model.sv
`default_nettype none

// ----------------------------------------
// decimation filter stand-in
// ----------------------------------------
module aogc_filter_model (
    input wire logic CLK,
    output logic RAW_VALID,
    output logic [23:0] RAW_DATA
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        RAW_VALID = 1'b0;
        RAW_DATA = 24'h00_0000;
    end

    // one 24-bit bipolar word per call
    // data flips once the strobe drops, so a late sample cannot pass
    task automatic emit(input logic [23:0] v);
        @(posedge CLK);
        #1;
        RAW_VALID = 1'b1;
        RAW_DATA = v;
        @(posedge CLK);
        #1;
        RAW_VALID = 1'b0;
        RAW_DATA = ~v;
    endtask : emit
endmodule : aogc_filter_model

`default_nettype wire

// file: test/adc_offset_gain_calibration_tb_top.sv
`default_nettype none

module adc_offset_gain_calibration_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rvld;
    logic [23:0] rdat;
    logic [1:0] gsel = 2'd0;
    logic uni = 1'b0;
    logic cstart = 1'b0;
    aogc_pkg::aogc_cal_t csel = aogc_pkg::CAL_NONE;
    logic owr = 1'b0;
    logic gwr = 1'b0;
    logic [23:0] owd = 24'h00_0000;
    logic [23:0] gwd = 24'h00_0000;
    logic [3:0] psel = 4'h0;
    logic [3:0] nsel = 4'h0;
    logic [15:0] res;
    logic rv;
    logic [23:0] d_ofs;
    logic [23:0] d_gain;
    logic busy;
    logic shrt;
    logic refi;
    logic temp;
    logic [23:0] ofs_m = 24'h00_0000;
    logic [23:0] gn_m = 24'h80_0000;
    logic [23:0] raws [4] = '{24'h12_3456, 24'hF0_0000, 24'h7F_FFFF, 24'h00_4000};
    int bad_count = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    aogc_filter_model flt (.CLK(clk), .RAW_VALID(rvld), .RAW_DATA(rdat));

    aogc_calibration DUT (
        .CLK(clk), .RST_N(rst_n), .RAW_VALID(rvld), .RAW_DATA(rdat),
        .GAIN_SEL(gsel), .UNIPOLAR(uni), .CAL_START(cstart), .CAL_SEL(csel),
        .OFFSET_WR(owr), .OFFSET_WDATA(owd), .GAIN_WR(gwr), .GAIN_WDATA(gwd),
        .POSITIVE_INPUT_SELECT(psel), .NEGATIVE_INPUT_SELECT(nsel),
        .RESULT(res), .RESULT_VALID(rv), .OFFSET_CORRECTION_VALUE(d_ofs),
        .GAIN_CORRECTION_VALUE(d_gain), .CAL_BUSY(busy), .SHORT_INPUTS(shrt),
        .REF_TO_INPUT(refi), .TEMP_SENSOR_ON(temp)
    );

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // floor product, shift by gain code plus unipolar doubling, then saturate
    function automatic logic [15:0] exp_res(input logic [23:0] raw, input logic [1:0] g,
        input logic u);
        longint d;
        longint c;
        longint s;
        d = longint'(signed'(raw)) - longint'(signed'(ofs_m));
        c = (d * longint'(gn_m)) >>> 23;
        s = c <<< (int'(g) + int'(u));
        if (u && c < 0)
            return 16'h0000;
        if (u && s > 64'sh00FF_FFFF)
            return 16'hFFFF;
        if (!u && s > 64'sh007F_FFFF)
            return 16'h7FFF;
        if (!u && s < -64'sh0080_0000)
            return 16'h8000;
        return s[23:8];
    endfunction : exp_res

    function automatic logic [23:0] exp_gain(input logic [23:0] raw);
        longint d;
        longint q;
        d = longint'(signed'(raw)) - longint'(signed'(ofs_m));
        if (d <= 0)
            return 24'hFF_FFFF;
        q = (64'sh0000_4000_0000_0000) / d;
        return (q > 64'sh00FF_FFFF) ? 24'hFF_FFFF : q[23:0];
    endfunction : exp_gain

    task automatic conv(input logic [23:0] raw);
        logic [15:0] e;
        e = exp_res(raw, gsel, uni);
        flt.emit(raw);
        chk({23'h00_0000, rv}, 24'h00_0001);
        chk({8'h00, res}, {8'h00, e});
    endtask : conv

    task automatic wr(input logic sel, input logic [23:0] v);
        @(posedge clk);
        #1;
        owr = !sel;
        gwr = sel;
        owd = v;
        gwd = v;
        if (sel)
            gn_m = v;
        else
            ofs_m = v;
        @(posedge clk);
        #1;
        owr = 1'b0;
        gwr = 1'b0;
        chk(sel ? d_gain : d_ofs, v);
    endtask : wr

    task automatic cal(input aogc_pkg::aogc_cal_t k, input logic [23:0] raw);
        int n;
        logic [15:0] held;
        held = res;
        @(posedge clk);
        #1;
        cstart = 1'b1;
        csel = k;
        @(posedge clk);
        #1;
        cstart = 1'b0;
        chk({23'h00_0000, busy}, 24'h00_0001);
        chk({22'h00_0000, shrt, refi},
            {22'h00_0000, k == aogc_pkg::CAL_SELF_OFS, k == aogc_pkg::CAL_SELF_GAIN});
        if (k == aogc_pkg::CAL_SELF_OFS || k == aogc_pkg::CAL_SYS_OFS)
            ofs_m = raw;
        else
            gn_m = exp_gain(raw);
        flt.emit(raw);
        // a conversion offered while dividing must not reach the data register
        if (k == aogc_pkg::CAL_SELF_GAIN)
            flt.emit(24'h55_5555);
        chk({7'h00, rv, res}, {8'h00, held});
        n = 0;
        while (busy !== 1'b0 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (busy !== 1'b0)
        begin
            bad_count++;
            results();
        end
        else
        begin
            chk(d_ofs, ofs_m);
            chk(d_gain, gn_m);
        end
    endtask : cal

    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        chk(d_ofs, 24'h00_0000);
        chk(d_gain, 24'h80_0000);
        chk({7'h00, rv, res}, 24'h00_0000);
        for (int i = 0; i < 32; i++)
        begin
            gsel = i[1:0];
            uni = i[2];
            conv(raws[i / 8]);
        end
        wr(1'b0, 24'hFF_F000);
        gsel = 2'd1;
        uni = 1'b0;
        wr(1'b1, 24'hC0_0000);
        chk({8'h00, res}, {8'h00, 16'h0400});
        conv(24'h10_0000);
        cal(aogc_pkg::CAL_SELF_OFS, 24'h00_0123);
        cal(aogc_pkg::CAL_SELF_GAIN, 24'h60_0123);
        chk(d_gain, 24'hAA_AAAA);
        conv(24'h30_0000);
        cal(aogc_pkg::CAL_SYS_OFS, 24'hFF_FFF0);
        cal(aogc_pkg::CAL_SYS_GAIN, 24'h7F_FFF0);
        chk(d_gain, 24'h80_0000);
        conv(24'hC0_0000);
        // a start with no operation selected must leave the sequencer idle
        @(posedge clk);
        #1;
        cstart = 1'b1;
        csel = aogc_pkg::CAL_NONE;
        @(posedge clk);
        #1;
        cstart = 1'b0;
        chk({23'h00_0000, busy}, 24'h00_0000);
        psel = 4'h7;
        @(posedge clk);
        #1;
        chk({23'h00_0000, temp}, 24'h00_0001);
        nsel = 4'h1;
        @(posedge clk);
        #1;
        chk({23'h00_0000, temp}, 24'h00_0000);
        results();
    end
endmodule : adc_offset_gain_calibration_tb_top

`default_nettype wire
